// ==== ifcs_sequencer.sv ====
// Flash command sequencer: mailbox registers, command decode and flash macro control.
// Assumes a flash macro on the same clock that pulses flash_done once per request,
// and a core that reports where the current instruction was fetched from.
//
// Implementation choices: the register offsets and register access over Wishbone.

module ifcs_sequencer
  import ifcs_pkg::*;
(
  input  wire logic        ref_clk,                    // 40 MHz core clock.
  input  wire logic        rst_b,                      // Core reset, async, active low.
  input  wire logic        por_b,                      // Power-on reset of nonvolatile bits.
  input  wire logic        wb_cyc_i,                   // Wishbone cycle.
  input  wire logic        wb_stb_i,                   // Wishbone strobe.
  input  wire logic        wb_we_i,                    // Wishbone write enable.
  input  wire logic [7:0]  wb_adr_i,                   // Wishbone byte address.
  input  wire logic [3:0]  wb_sel_i,                   // Wishbone byte selects.
  input  wire logic [31:0] wb_dat_i,                   // Wishbone write data.
  output logic      [31:0] wb_dat_o,                   // Wishbone read data.
  output logic             wb_ack_o,                   // Wishbone acknowledge.
  input  wire logic        external_execution_pin,     // Low selects external execution.
  input  wire logic        programming_disable_pin,    // Low at reset disables commands.
  input  wire logic        external_interrupt_one_pin, // Interrupt pin, raw.
  input  wire logic [1:0]  fetch_origin,               // 0 primary, 1 secondary, 2/3 external.
  output logic             flash_req,                  // One-cycle operation request.
  output ifcs_fop_t        flash_op,                   // Operation kind.
  output logic             flash_block,                // Target block.
  output logic      [15:0] flash_addr,                 // Target address.
  output logic      [7:0]  flash_wdata,                // Program data.
  input  wire logic        flash_done,                 // One-cycle completion.
  input  wire logic [7:0]  flash_rdata,                // Read data, valid with done.
  input  wire logic        table_read_req,             // Core table read request.
  input  wire logic        table_read_block,           // Block the table read targets.
  output logic             table_read_fail,            // Table read refused.
  output logic      [1:0]  block_busy,                 // Per-block busy.
  output logic             external_interrupt_one,     // Interrupt 1 source to the core.
  output logic             clock_double,               // Six clocks per machine cycle.
  output logic             boot_block_select,          // Boot select, frozen from reset.
  output logic             config_bit_one              // Config bit one, frozen from reset.
);

  logic [7:0]  flash_command_reg, flash_addr_low_reg, flash_addr_high_reg, flash_data_reg;
  logic [7:0]  flash_config_reg;
  logic [5:0]  nv_bits, dec_mask;
  logic [1:0]  ext_sync, dis_sync, int_sync, cap_cnt;
  logic        iap_disabled, dec_valid, dec_blk, cmd_wr, accept, busy, irq_mode;
  logic [1:0]  lock, ab;
  ifcs_fop_t   dec_op;
  ifcs_state_t state;
  logic [5:0]  op_mask;

  // Block chosen by address high: bit 1 is valid, bit 0 the block.
  function automatic logic [1:0] ifcs_addr_block(input logic [7:0] ah);
    if (!ah[7]) begin
      return 2'b10;
    end else if (ah[7:5] == AH_BLK1_TOP) begin
      return 2'b11;
    end
    return 2'b00;
  endfunction : ifcs_addr_block

  // Pins come from outside the clock domain; only the second stage is read.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_sync <= 2'b11;
      dis_sync <= 2'b11;
      int_sync <= 2'b11;
    end else begin
      ext_sync <= {ext_sync[0], external_execution_pin};
      dis_sync <= {dis_sync[0], programming_disable_pin};
      int_sync <= {int_sync[0], external_interrupt_one_pin};
    end
  end

  // Straps are caught once the pin has passed the synchroniser after release.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cap_cnt           <= 2'h0;
      iap_disabled      <= 1'b1;
      boot_block_select <= 1'b0;
      config_bit_one    <= 1'b0;
    end else if (cap_cnt != CAPTURE_AT) begin
      cap_cnt <= cap_cnt + 2'h1;
      if (cap_cnt + 2'h1 == CAPTURE_AT) begin
        iap_disabled      <= !dis_sync[1];
        boot_block_select <= nv_bits[NV_SC0];
        config_bit_one    <= nv_bits[NV_SC1];
      end
    end
  end

  // Locking: any programmed security bit locks a block; all three is level 4.
  assign lock[0]  = nv_bits[NV_SB1] | nv_bits[NV_SB2];
  assign lock[1]  = nv_bits[NV_SB1] | nv_bits[NV_SB3];
  assign ab       = ifcs_addr_block(flash_addr_high_reg);
  assign irq_mode = flash_command_reg[CMD_IRQ_BIT];

  // Decode of the command byte being written against the mailbox contents.
  always_comb begin
    dec_valid = 1'b0;
    dec_op    = FOP_NVBIT;
    dec_mask  = 6'h00;
    dec_blk   = (fetch_origin == 2'd0);
    unique case (wb_dat_i[6:0])
      OPC_CHIP_ERASE: begin
        dec_op    = FOP_ERASE_CHIP;
        dec_valid = flash_data_reg == KEY_ERASE && !ext_sync[1] && !(&nv_bits[2:0]);
      end
      OPC_BLOCK_ERASE: begin
        dec_op = FOP_ERASE_BLOCK;
        if (fetch_origin[1]) begin
          dec_blk   = flash_addr_high_reg[7];
          dec_valid = !flash_addr_high_reg[7] || flash_addr_high_reg[7:4] == AH_BLK1_NIBBLE;
        end else begin
          dec_valid = 1'b1;
        end
        dec_valid = dec_valid && flash_data_reg == KEY_ERASE && !lock[dec_blk];
      end
      OPC_SECTOR_ERASE, OPC_BYTE_PROGRAM, OPC_BYTE_VERIFY: begin
        dec_op = (wb_dat_i[6:0] == OPC_SECTOR_ERASE) ? FOP_ERASE_SECTOR :
                 (wb_dat_i[6:0] == OPC_BYTE_PROGRAM) ? FOP_PROGRAM : FOP_READ;
        if (fetch_origin[1]) begin
          dec_blk = ab[0];
        end
        dec_valid = (!fetch_origin[1] || ab[1]) && !lock[dec_blk];
      end
      OPC_SEC_BIT_ONE, OPC_SEC_BIT_TWO, OPC_SEC_BIT_THREE: begin
        dec_valid = flash_data_reg == KEY_PROGRAM;
        dec_mask  = (wb_dat_i[6:0] == OPC_SEC_BIT_ONE) ? 6'h01 :
                    (wb_dat_i[6:0] == OPC_SEC_BIT_TWO) ? 6'h02 : 6'h04;
      end
      OPC_OVERLAY: begin
        dec_valid = flash_data_reg == KEY_PROGRAM &&
                    (flash_addr_high_reg == AH_OVERLAY_ZERO ||
                     flash_addr_high_reg == AH_OVERLAY_ONE);
        dec_mask  = (flash_addr_high_reg == AH_OVERLAY_ZERO) ? 6'h08 : 6'h10;
      end
      OPC_CLOCK_DOUBLE: begin
        dec_valid = flash_data_reg == KEY_PROGRAM && flash_addr_high_reg == AH_CLOCK_DOUBLE;
        dec_mask  = 6'h20;
      end
      default: dec_valid = 1'b0;
    endcase
  end

  // Writes act on the edge where the master samples ack.
  assign cmd_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] &&
                  wb_adr_i == OFS_CMD;
  assign accept = cmd_wr && flash_config_reg[CFG_IAP_EN_BIT] && !iap_disabled &&
                  state == ST_IDLE && dec_valid;

  // Operation sequencing; busy ends only with the macro's completion.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state       <= ST_IDLE;
      flash_req   <= 1'b0;
      flash_op    <= FOP_NVBIT;
      flash_block <= 1'b0;
      flash_addr  <= 16'h0000;
      flash_wdata <= 8'h00;
      op_mask     <= 6'h00;
    end else begin
      flash_req <= accept;
      if (accept) begin
        state       <= (dec_op == FOP_READ) ? ST_READ : ST_RUN;
        flash_op    <= dec_op;
        flash_block <= dec_blk;
        flash_addr  <= {flash_addr_high_reg, flash_addr_low_reg};
        flash_wdata <= flash_data_reg;
        op_mask     <= dec_mask;
      end else if (flash_done && state != ST_IDLE) begin
        state <= ST_IDLE;
      end
    end
  end

  assign busy            = (state == ST_RUN);
  assign block_busy[0]   = busy && flash_op != FOP_NVBIT && (flash_block == 1'b0 ||
                           flash_op == FOP_ERASE_CHIP);
  assign block_busy[1]   = busy && flash_op != FOP_NVBIT && (flash_block == 1'b1 ||
                           flash_op == FOP_ERASE_CHIP);
  assign table_read_fail = table_read_req && block_busy[table_read_block];

  // Nonvolatile bits survive core reset; set-only except for chip erase.
  always_ff @(posedge ref_clk or negedge por_b) begin
    if (!por_b) begin
      nv_bits <= NV_RST;
    end else if (busy && flash_done) begin
      if (flash_op == FOP_ERASE_CHIP) begin
        nv_bits <= nv_bits & ~NV_LOCKS;
      end else begin
        nv_bits <= nv_bits | op_mask;
      end
    end
  end
  assign clock_double = nv_bits[NV_CLK];

  // With command bit 7 set, completion of any operation but verify raises interrupt 1 internally and the pin is masked.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      external_interrupt_one <= 1'b1;
    end else if (irq_mode) begin
      external_interrupt_one <= !(busy && flash_done);
    end else begin
      external_interrupt_one <= int_sync[1];
    end
  end

  // Mailbox registers; a verify result overrides a software write.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      flash_command_reg   <= CMD_RST;
      flash_addr_low_reg  <= MBOX_RST;
      flash_addr_high_reg <= MBOX_RST;
      flash_data_reg      <= MBOX_RST;
      flash_config_reg    <= CFG_RST;
    end else begin
      if (cmd_wr) begin
        flash_command_reg <= wb_dat_i[7:0];
      end
      if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]) begin
        if (wb_adr_i == OFS_ADDR_LOW) flash_addr_low_reg <= wb_dat_i[7:0];
        if (wb_adr_i == OFS_ADDR_HIGH) flash_addr_high_reg <= wb_dat_i[7:0];
        if (wb_adr_i == OFS_CONFIG) flash_config_reg <= wb_dat_i[7:0];
        if (wb_adr_i == OFS_DATA) flash_data_reg <= wb_dat_i[7:0];
      end
      if (state == ST_READ && flash_done) begin
        flash_data_reg <= flash_rdata;
      end
    end
  end

  // Wishbone answer one cycle after the request; unmapped reads return zero.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= 32'h0000_0000;
      unique case (wb_adr_i)
        OFS_CMD:       wb_dat_o[7:0] <= flash_command_reg;
        OFS_STATUS:    wb_dat_o[STATUS_BUSY_BIT] <= busy;
        OFS_ADDR_LOW:  wb_dat_o[7:0] <= flash_addr_low_reg;
        OFS_ADDR_HIGH: wb_dat_o[7:0] <= flash_addr_high_reg;
        OFS_DATA:      wb_dat_o[7:0] <= flash_data_reg;
        OFS_CONFIG: begin
          wb_dat_o[CFG_IAP_EN_BIT] <= flash_config_reg[CFG_IAP_EN_BIT];
          wb_dat_o[CFG_SC1_BIT]    <= config_bit_one;
          wb_dat_o[CFG_BOOT_BLOCK_SELECT_BIT]   <= boot_block_select;
        end
        OFS_NVBITS:    wb_dat_o[5:0] <= nv_bits;
        default:       wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Checks of the sequencing behaviour.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b || !por_b);

  property p_start_by_write;
    flash_req |-> $past(cmd_wr) && $past(flash_config_reg[CFG_IAP_EN_BIT]);
  endproperty
  a_start_by_write: assert property (p_start_by_write) else $error("start without write");
  property p_lock;
    flash_req && flash_op != FOP_NVBIT && flash_op != FOP_ERASE_CHIP |-> !$past(lock[dec_blk]);
  endproperty
  a_lock: assert property (p_lock) else $error("command to locked block");
  property p_chip;
    flash_req && flash_op == FOP_ERASE_CHIP |-> $past(!ext_sync[1] && !(&nv_bits[2:0]));
  endproperty
  a_chip: assert property (p_chip) else $error("chip erase not allowed");
  property p_verify_quiet;
    flash_req && flash_op == FOP_READ |-> !busy throughout (state == ST_READ)[*2];
  endproperty
  a_verify_quiet: assert property (p_verify_quiet) else $error("verify raised busy");
  property p_nv_monotonic;
    busy && flash_done && flash_op != FOP_ERASE_CHIP |=> (nv_bits & $past(nv_bits)) == $past(nv_bits);
  endproperty
  a_nv_monotonic: assert property (p_nv_monotonic) else $error("nv bit cleared");
  property p_boot_block_select_frozen;
    cap_cnt == CAPTURE_AT |=> $stable(boot_block_select) && $stable(config_bit_one);
  endproperty
  a_boot_block_select_frozen: assert property (p_boot_block_select_frozen) else $error("boot select moved");
  property p_busy;
    flash_req && flash_op != FOP_READ |-> busy;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not raised");
  property p_table;
    table_read_req && block_busy[table_read_block] |-> table_read_fail;
  endproperty
  a_table: assert property (p_table) else $error("table read not refused");
  property p_irq;
    !external_interrupt_one && $past(irq_mode) |-> $past(busy && flash_done);
  endproperty
  a_irq: assert property (p_irq) else $error("spurious completion interrupt");
  property p_gate;
    cmd_wr && (!flash_config_reg[CFG_IAP_EN_BIT] || iap_disabled) |=> !flash_req;
  endproperty
  a_gate: assert property (p_gate) else $error("command ran while disabled");

  c_program: cover property (flash_req && flash_op == FOP_PROGRAM ##[1:50] flash_done);
  c_verify:  cover property (state == ST_READ && flash_done);
  c_irq:     cover property (irq_mode && busy && flash_done);
  c_nvbit:   cover property (flash_req && flash_op == FOP_NVBIT);

endmodule : ifcs_sequencer

// ==== ifcs_pkg.sv ====
// Constants and types shared by the flash command sequencer.
// Assumes a 32-bit classic Wishbone register bus and one 8-bit flash macro port.
package ifcs_pkg;

  // Register byte offsets on the Wishbone bus.
  localparam logic [7:0] OFS_CMD       = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_ADDR_LOW  = 8'h08;
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h0c;
  localparam logic [7:0] OFS_DATA      = 8'h10;
  localparam logic [7:0] OFS_CONFIG    = 8'h14;
  localparam logic [7:0] OFS_NVBITS    = 8'h18;

  // Opcodes held in command bits 6:0.
  localparam logic [6:0] OPC_CHIP_ERASE   = 7'h01;
  localparam logic [6:0] OPC_BLOCK_ERASE  = 7'h0d;
  localparam logic [6:0] OPC_SECTOR_ERASE = 7'h0b;
  localparam logic [6:0] OPC_BYTE_PROGRAM = 7'h0e;
  localparam logic [6:0] OPC_BYTE_VERIFY  = 7'h0c;
  localparam logic [6:0] OPC_SEC_BIT_ONE  = 7'h0f;
  localparam logic [6:0] OPC_SEC_BIT_TWO  = 7'h03;
  localparam logic [6:0] OPC_SEC_BIT_THREE = 7'h05;
  localparam logic [6:0] OPC_OVERLAY      = 7'h09;
  localparam logic [6:0] OPC_CLOCK_DOUBLE = 7'h08;

  // Key values expected in the data and address-high mailboxes.
  localparam logic [7:0] KEY_ERASE       = 8'h55;
  localparam logic [7:0] KEY_PROGRAM     = 8'haa;
  localparam logic [7:0] AH_OVERLAY_ZERO = 8'h5a;
  localparam logic [7:0] AH_OVERLAY_ONE  = 8'haa;
  localparam logic [7:0] AH_CLOCK_DOUBLE = 8'h55;
  localparam logic [3:0] AH_BLK1_NIBBLE  = 4'he;
  localparam logic [2:0] AH_BLK1_TOP     = 3'b111;

  // Field positions.
  localparam int CMD_IRQ_BIT     = 7;
  localparam int STATUS_BUSY_BIT = 2;
  localparam int CFG_IAP_EN_BIT  = 6;
  localparam int CFG_SC1_BIT     = 1;
  localparam int CFG_BOOT_BLOCK_SELECT_BIT    = 0;
  localparam int NV_SB1 = 0;
  localparam int NV_SB2 = 1;
  localparam int NV_SB3 = 2;
  localparam int NV_SC0 = 3;
  localparam int NV_SC1 = 4;
  localparam int NV_CLK = 5;

  // Reset values.
  localparam logic [7:0] CMD_RST    = 8'h00;
  localparam logic [7:0] CFG_RST    = 8'h00;
  localparam logic [7:0] MBOX_RST   = 8'h00;
  localparam logic [5:0] NV_RST     = 6'h00;
  localparam logic [5:0] NV_LOCKS   = 6'h1f;
  // The strap synchroniser is held at one in reset, so the pin needs two edges to arrive.
  localparam logic [1:0] CAPTURE_AT = 2'h3;

  typedef enum logic [2:0] {
    FOP_ERASE_CHIP, FOP_ERASE_BLOCK, FOP_ERASE_SECTOR, FOP_PROGRAM, FOP_READ, FOP_NVBIT
  } ifcs_fop_t;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_READ} ifcs_state_t;

endpackage : ifcs_pkg

// ==== iap_flash_command_sequencer_test.sv ====
// Self-checking bench for the flash command sequencer, driven over classic Wishbone.
// Assumes the bench stands in for the flash macro, the core and the strap pins.
module iap_flash_command_sequencer_test;
  import ifcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk, rst_b, por_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        external_execution_pin, programming_disable_pin, external_interrupt_one_pin;
  logic [1:0]  fetch_origin, block_busy;
  logic        flash_req, flash_block, flash_done, table_read_req, table_read_block;
  logic        table_read_fail, external_interrupt_one, clock_double;
  logic        boot_block_select, config_bit_one;
  ifcs_fop_t   flash_op;
  logic [15:0] flash_addr;
  logic [7:0]  flash_wdata, flash_rdata, rd;
  logic [3:0]  mac_cnt;
  int          fails, cmp_count, req_count, irq_count, r0, i0;

  ifcs_sequencer u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .por_b(por_b), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .external_execution_pin(external_execution_pin),
    .programming_disable_pin(programming_disable_pin),
    .external_interrupt_one_pin(external_interrupt_one_pin), .fetch_origin(fetch_origin),
    .flash_req(flash_req), .flash_op(flash_op), .flash_block(flash_block),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_done(flash_done),
    .flash_rdata(flash_rdata), .table_read_req(table_read_req),
    .table_read_block(table_read_block), .table_read_fail(table_read_fail),
    .block_busy(block_busy), .external_interrupt_one(external_interrupt_one),
    .clock_double(clock_double), .boot_block_select(boot_block_select),
    .config_bit_one(config_bit_one));

  // The clock toggles every half period of 12.5 ns.
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Flash macro stand-in: a slow fixed latency so that busy can be seen over the bus.
  always @(posedge ref_clk) begin
    if (flash_req === 1'b1) begin
      mac_cnt <= 4'd8;
      req_count <= req_count + 1;
    end else if (mac_cnt != 4'd0) begin
      mac_cnt <= mac_cnt - 4'd1;
    end
    flash_done <= (mac_cnt == 4'd1);
    if (external_interrupt_one === 1'b0) begin
      irq_count <= irq_count + 1; // Counting stands in for enabled edge interrupts.
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One classic cycle; read data is taken at the edge where ack is sampled high.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h000000, wd};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o[7:0];
    if (n >= 20) begin
      fails++;
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic cmd(input logic [7:0] c, input logic [7:0] ah, input logic [7:0] al,
                     input logic [7:0] dt);
    wb(1'b1, OFS_ADDR_HIGH, ah);
    wb(1'b1, OFS_ADDR_LOW, al);
    wb(1'b1, OFS_DATA, dt);
    r0 = req_count;
    i0 = irq_count;
    wb(1'b1, OFS_CMD, c);
  endtask : cmd

  // Polls the busy flag; a bounded number of reads keeps a stuck flag from hanging.
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      wb(1'b0, OFS_STATUS, 8'h00);
      n++;
    end while (rd[STATUS_BUSY_BIT] !== 1'b0 && n < 40);
    repeat (2) @(posedge ref_clk);
  endtask : wait_idle

  task automatic do_reset(input logic dis_pin);
    programming_disable_pin <= dis_pin;
    rst_b <= 1'b0;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    por_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask : do_reset

  task automatic t_program();
    cmd(8'h0e, 8'h12, 8'h34, 8'ha5);
    wait_idle();
    check("req_while_off", req_count - r0, 0);
    wb(1'b1, OFS_CONFIG, 8'h40);
    cmd(8'h8e, 8'h12, 8'h34, 8'ha5); // Erased location, external fetch.
    wb(1'b0, OFS_STATUS, 8'h00);
    check("busy_run", rd[STATUS_BUSY_BIT], 1);
    table_read_req <= 1'b1;
    table_read_block <= 1'b0;
    @(negedge ref_clk);
    check("table_fail", table_read_fail, 1);
    @(posedge ref_clk);
    table_read_req <= 1'b0;
    wait_idle(); // Verify follows only after busy has dropped.
    check("req_prog", req_count - r0, 1);
    check("op_prog", flash_op, FOP_PROGRAM);
    check("addr_prog", flash_addr, 16'h1234);
    check("wdata_prog", flash_wdata, 8'ha5);
    check("irq_prog", irq_count - i0, 1);
    $display("test program done");
  endtask : t_program

  task automatic t_verify();
    int n;
    n = 0;
    cmd(8'h8c, 8'h12, 8'h34, 8'h00);
    do begin
      wb(1'b0, OFS_DATA, 8'h00);
      n++;
    end while (rd !== flash_rdata && n < 20);
    check("verify_data", rd, 8'h5c);
    check("op_verify", flash_op, FOP_READ);
    repeat (3) @(posedge ref_clk);
    check("irq_verify", irq_count - i0, 0);
    $display("test verify done");
  endtask : t_verify

  task automatic t_decode();
    fetch_origin <= 2'd0;
    cmd(8'h0b, 8'h01, 8'h80, 8'h00);
    wait_idle();
    check("blk_internal", flash_block, 1);
    check("op_sector", flash_op, FOP_ERASE_SECTOR);
    check("addr_sector", flash_addr, 16'h0180);
    fetch_origin <= 2'd2;
    cmd(8'h02, 8'h00, 8'h00, 8'h55);
    wait_idle();
    check("req_undef", req_count - r0, 0);
    cmd(8'h0d, 8'he0, 8'h00, 8'h54);
    wait_idle();
    check("req_badkey", req_count - r0, 0);
    cmd(8'h0d, 8'he0, 8'h00, 8'h55);
    wait_idle();
    check("blk_erase", {flash_op, flash_block}, {FOP_ERASE_BLOCK, 1'b1});
    $display("test decode done");
  endtask : t_decode

  task automatic t_bits();
    cmd(8'h03, 8'h00, 8'h00, 8'haa); // Issued from external code.
    wait_idle();
    cmd(8'h0e, 8'h10, 8'h00, 8'h11);
    wait_idle();
    check("req_locked", req_count - r0, 0);
    cmd(8'h0e, 8'he0, 8'h00, 8'h11);
    wait_idle();
    check("req_other_blk", req_count - r0, 1);
    cmd(8'h08, 8'h55, 8'h00, 8'haa);
    wait_idle();
    check("clk_double", clock_double, 1);
    cmd(8'h09, 8'h5a, 8'h00, 8'haa);
    wait_idle();
    cmd(8'h09, 8'haa, 8'h00, 8'haa);
    wait_idle();
    check("boot_block_select_frozen", boot_block_select, 0);
    check("cfg1_frozen", config_bit_one, 0);
    wb(1'b0, OFS_NVBITS, 8'h00);
    check("nv_bits", rd, 8'h3a);
    cmd(8'h01, 8'h00, 8'h00, 8'h55);
    wait_idle();
    check("req_chip_pin_hi", req_count - r0, 0);
    external_execution_pin <= 1'b0;
    repeat (4) @(posedge ref_clk);
    cmd(8'h01, 8'h00, 8'h00, 8'h55);
    wait_idle();
    check("op_chip", flash_op, FOP_ERASE_CHIP);
    wb(1'b0, OFS_NVBITS, 8'h00);
    check("nv_after_chip", rd, 8'h20);
    $display("test bits done");
  endtask : t_bits

  task automatic t_strap();
    do_reset(1'b0);
    wb(1'b1, OFS_CONFIG, 8'h40);
    cmd(8'h0e, 8'h12, 8'h00, 8'h01);
    wait_idle();
    check("req_strap", req_count - r0, 0);
    external_interrupt_one_pin <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check("pin_passthru", external_interrupt_one, 0);
    external_interrupt_one_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    $display("test strap done");
  endtask : t_strap

  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  // Watchdog sized well above the few hundred cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    test_done();
  end

  initial begin
    {rst_b, por_b, wb_cyc_i, wb_stb_i, wb_we_i, flash_done, table_read_req} = '0;
    {table_read_block, fails, cmp_count, req_count, irq_count, mac_cnt} = '0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h1;
    wb_dat_i = 32'h00000000;
    external_execution_pin = 1'b1;
    programming_disable_pin = 1'b1;
    external_interrupt_one_pin = 1'b1;
    fetch_origin = 2'd2;
    flash_rdata = 8'h5c;
    do_reset(1'b1);
    t_program();
    t_verify();
    t_decode();
    t_bits();
    t_strap();
    test_done();
  end
endmodule : iap_flash_command_sequencer_test
